// ### rsc_defs.svh
// Constants of the reset source controller: register map, bit positions, timing.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define IDX_CAUSE 8'hEF
`define IDX_SUPPLY 8'hFF
`define ADDR_CAUSE ({2'h0, `IDX_CAUSE, 2'h0})
`define ADDR_SUPPLY ({2'h0, `IDX_SUPPLY, 2'h0})

`define B_PIN 0
`define B_POR 1
`define B_CLK 2
`define B_WDT 3
`define B_SW 4
`define B_CMP 5
`define B_FLASH 6
`define B_MON_ON 7
`define B_SUPPLY_OK 6

`define CLK_PERIOD_NS 10
`define RST_STRETCH_NS 1000
`define RST_STRETCH_CYC ((`RST_STRETCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_LOSS_CYC 100
`define WDT_DIV 12
`define WDT_DIV_LAST 4'hB
`define PORT_RST_VAL 8'hFF
`define PC_RST_VAL 16'h0000
`define CNT_MAX 65535

`endif

// ### rsc_pkg.sv
// Types shared by the reset source controller and its clock-loss detector.
package rsc_pkg;

    typedef enum logic {ST_HOLD, ST_RUN} rst_state_t;

    typedef enum logic [1:0] {SEL_NONE, SEL_CAUSE, SEL_SUPPLY} reg_sel_t;

    typedef struct packed {
        rst_state_t st;
        logic [15:0] cnt;
        logic [7:0] pend;
        logic [7:0] flags;
        logic en_supply;
        logic en_clk;
        logic en_cmp;
        logic mon_on;
        logic drive_pin;
        logic [3:0] div;
        logic tick;
        logic pc_clear;
        logic dph_wr;
        reg_sel_t dph_sel;
        logic [7:0] rdata;
    } rsc_state_t;

    typedef struct packed {
        logic last;
        logic [15:0] cnt;
        logic loss;
    } cld_state_t;

endpackage : rsc_pkg

// ### clock_loss_detector.sv
// Level flag, held until the clock toggles or enable is cleared, for a monitored clock stuck high or low past a timeout.
`timescale 1ns/100ps
`include "rsc_defs.svh"

module clock_loss_detector #(
    parameter int unsigned TIMEOUT = `CLK_LOSS_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic monitored_clk,
    output logic clock_lost
);
    import rsc_pkg::*;

    cld_state_t s_r;
    cld_state_t s_nxt;

    generate
        if (TIMEOUT < 2 || TIMEOUT > `CNT_MAX)
        begin : g_bad_timeout
            $error("clock_loss_detector: TIMEOUT out of range");
        end
    endgenerate

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.last = monitored_clk;
        if (!enable)
        begin
            s_nxt.cnt = 16'h0000;
            s_nxt.loss = 1'b0;
        end
        else if (monitored_clk != s_r.last)
        begin
            s_nxt.cnt = 16'h0000;
            s_nxt.loss = 1'b0;
        end
        else if (s_r.cnt != 16'(TIMEOUT))
        begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
        else
        begin
            s_nxt.loss = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign clock_lost = s_r.loss;

endmodule : clock_loss_detector

// ### reset_source_controller.sv
// Reset source controller: merges reset causes, records them, AHB-Lite registers.
`timescale 1ns/100ps
`include "rsc_defs.svh"

module reset_source_controller #(
    parameter int unsigned STRETCH_CYC = `RST_STRETCH_CYC,
    parameter int unsigned CLK_LOSS_CYC = `CLK_LOSS_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe,
    input wire logic supply_above_threshold,
    input wire logic comparator_out_n,
    input wire logic watchdog_overflow,
    input wire logic flash_fault,
    input wire logic monitored_clk,
    output logic sys_rst_n,
    output logic cpu_halt,
    output logic sfr_init,
    output logic ram_write_block,
    output logic [7:0] port_latch_val,
    output logic port_latch_load,
    output logic port_open_drain,
    output logic weak_pullup_en,
    output logic irq_timer_disable,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic sysclk_internal_sel,
    output logic wdt_enable,
    output logic wdt_tick,
    output rsc_pkg::rst_state_t reset_phase
);
    import rsc_pkg::*;

    rsc_state_t s_r;
    rsc_state_t s_nxt;
    logic clock_lost;
    logic [7:0] src;
    logic wr_cause;
    logic wr_supply;
    logic addr_phase;
    logic hit_cause;
    logic hit_supply;
    logic [7:0] cause_word;
    logic [7:0] supply_word;
    logic [7:0] pend_acc;

    generate
        if (STRETCH_CYC < 1 || STRETCH_CYC > `CNT_MAX)
        begin : g_bad_stretch
            $error("reset_source_controller: STRETCH_CYC out of range");
        end
        // The tick compare value and the divide ratio must agree
        if (`WDT_DIV_LAST != `WDT_DIV - 1)
        begin : g_bad_wdt_div
            $error("reset_source_controller: watchdog divider constants disagree");
        end
    endgenerate

    // Detector is idle while its enable bit is clear
    clock_loss_detector #(
        .TIMEOUT(CLK_LOSS_CYC)
    ) u_clock_loss (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(s_r.en_clk),
        .monitored_clk(monitored_clk),
        .clock_lost(clock_lost)
    );

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_cause = s_r.dph_wr && (s_r.dph_sel == SEL_CAUSE);
    assign wr_supply = s_r.dph_wr && (s_r.dph_sel == SEL_SUPPLY);

    // Address decode; unmapped addresses hit neither register
    always_comb
    begin
        hit_cause = 1'b0;
        hit_supply = 1'b0;
        if (haddr == `ADDR_CAUSE)
        begin
            hit_cause = 1'b1;
        end
        else if (haddr == `ADDR_SUPPLY)
        begin
            hit_supply = 1'b1;
        end
        else
        begin
            hit_cause = 1'b0;
        end
    end

    // Read words are built field by field so unused bits read zero
    always_comb
    begin
        cause_word = 8'h00;
        cause_word[`B_PIN] = s_r.flags[`B_PIN];
        cause_word[`B_POR] = s_r.flags[`B_POR];
        cause_word[`B_CLK] = s_r.flags[`B_CLK];
        cause_word[`B_WDT] = s_r.flags[`B_WDT];
        cause_word[`B_SW] = s_r.flags[`B_SW];
        cause_word[`B_CMP] = s_r.flags[`B_CMP];
        cause_word[`B_FLASH] = s_r.flags[`B_FLASH];
        supply_word = 8'h00;
        supply_word[`B_MON_ON] = s_r.mon_on;
        // Live monitor output, not a stored copy, so software sees dips
        supply_word[`B_SUPPLY_OK] = supply_above_threshold;
    end

    // Every cause bit accumulates alike while the hold lasts
    generate
        for (genvar i = 0; i < $bits(pend_acc); i++)
        begin : g_pend
            assign pend_acc[i] = s_r.pend[i] || src[i];
        end
    endgenerate

    // Reset sources; our own pin drive is masked so it cannot retrigger itself
    always_comb
    begin
        src = 8'h00;
        src[`B_PIN] = !rst_pin_i && !s_r.drive_pin;
        src[`B_POR] = s_r.mon_on && s_r.en_supply
            && !supply_above_threshold;
        src[`B_CLK] = clock_lost;
        src[`B_WDT] = watchdog_overflow;
        src[`B_SW] = wr_cause && hwdata[`B_SW];
        src[`B_CMP] = s_r.en_cmp && !comparator_out_n;
        src[`B_FLASH] = flash_fault;
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pc_clear = 1'b0;
        s_nxt.tick = 1'b0;

        // Address phase of the bus; read data is captured here so it
        // comes out of a flop during the data phase
        s_nxt.dph_wr = 1'b0;
        s_nxt.dph_sel = SEL_NONE;
        if (addr_phase)
        begin
            s_nxt.dph_wr = hwrite;
            if (hit_cause)
            begin
                s_nxt.dph_sel = SEL_CAUSE;
            end
            else if (hit_supply)
            begin
                s_nxt.dph_sel = SEL_SUPPLY;
            end
            else
            begin
                s_nxt.dph_sel = SEL_NONE;
            end
            if (!hwrite)
            begin
                if (hit_cause)
                begin
                    s_nxt.rdata = cause_word;
                end
                else if (hit_supply)
                begin
                    s_nxt.rdata = supply_word;
                end
                else
                begin
                    s_nxt.rdata = 8'h00;
                end
            end
        end

        // Data phase writes; each enable takes its own bit of the written value
        if (wr_supply)
        begin
            s_nxt.mon_on = hwdata[`B_MON_ON];
        end
        if (wr_cause)
        begin
            s_nxt.en_supply = hwdata[`B_POR];
            s_nxt.en_clk = hwdata[`B_CLK];
            s_nxt.en_cmp = hwdata[`B_CMP];
        end

        case (s_r.st)
            ST_RUN:
            begin
                if (s_r.div == `WDT_DIV_LAST)
                begin
                    s_nxt.div = 4'h0;
                    s_nxt.tick = 1'b1;
                end
                else
                begin
                    s_nxt.div = s_r.div + 4'h1;
                end
                if (src != 8'h00)
                begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.pend = src;
                    s_nxt.cnt = 16'(STRETCH_CYC - 1);
                    // Power-fail style causes own the pin for the whole hold
                    s_nxt.drive_pin = src[`B_POR];
                    // Detector and comparator enables are ordinary
                    // register state and return to their reset value;
                    // monitor enable and selection survive
                    s_nxt.en_clk = 1'b0;
                    s_nxt.en_cmp = 1'b0;
                    s_nxt.div = 4'h0;
                end
            end
            ST_HOLD:
            begin
                s_nxt.div = 4'h0;
                s_nxt.pend = pend_acc;
                if (src[`B_POR])
                begin
                    s_nxt.drive_pin = 1'b1;
                end
                if (src != 8'h00)
                begin
                    s_nxt.cnt = 16'(STRETCH_CYC - 1);
                end
                else if (s_r.cnt != 16'h0000)
                begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
                else
                begin
                    // Release on a clock edge, with the causes latched
                    s_nxt.st = ST_RUN;
                    s_nxt.flags = s_r.pend;
                    s_nxt.drive_pin = 1'b0;
                    s_nxt.pc_clear = 1'b1;
                end
            end
            default:
            begin
                s_nxt.st = ST_HOLD;
            end
        endcase
    end

    // Power-on is the async reset: hold state with the power flag pending,
    // the monitor switched on and selected, and the pin driven low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.st <= ST_HOLD;
            s_r.cnt <= 16'(STRETCH_CYC - 1);
            s_r.pend[`B_POR] <= 1'b1;
            s_r.mon_on <= 1'b1;
            s_r.en_supply <= 1'b1;
            s_r.drive_pin <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Bus answers with zero wait states and OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, s_r.rdata};

    // Open-drain: only ever pulls low
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe = s_r.drive_pin;

    assign sys_rst_n = (s_r.st == ST_RUN);
    assign cpu_halt = (s_r.st == ST_HOLD);
    assign sfr_init = (s_r.st == ST_HOLD);
    assign irq_timer_disable = (s_r.st == ST_HOLD);
    // Data memory keeps its contents; only writes are blocked in reset
    assign ram_write_block = (s_r.st == ST_HOLD);
    assign port_latch_val = `PORT_RST_VAL;
    assign port_latch_load = (s_r.st == ST_HOLD);
    assign port_open_drain = (s_r.st == ST_HOLD);
    assign weak_pullup_en = 1'b1;
    assign pc_load = s_r.pc_clear;
    assign pc_value = `PC_RST_VAL;
    assign sysclk_internal_sel = (s_r.st == ST_HOLD) || s_r.pc_clear;
    assign wdt_enable = (s_r.st == ST_RUN);
    assign wdt_tick = s_r.tick;
    assign reset_phase = s_r.st;

endmodule : reset_source_controller

// ### rsc_checker_assertions.sv
// Port-level assertions for the reset source controller.
`timescale 1ns/100ps
`include "rsc_defs.svh"

module rsc_checker #(
    parameter int unsigned STRETCH_CYC = 100,
    parameter int unsigned CLK_LOSS_CYC = 100
) (
    input logic clk_sys,
    input logic rst_n,
    input logic hsel,
    input logic [11:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [31:0] hwdata,
    input logic hready,
    input logic rst_pin_i,
    input logic rst_pin_oe,
    input logic supply_above_threshold,
    input logic sys_rst_n,
    input logic cpu_halt,
    input logic sfr_init,
    input logic ram_write_block,
    input logic irq_timer_disable,
    input logic [7:0] port_latch_val,
    input logic port_open_drain,
    input logic weak_pullup_en,
    input logic pc_load,
    input logic [15:0] pc_value,
    input logic sysclk_internal_sel,
    input logic wdt_enable,
    input logic wdt_tick
);
    logic seen_r;
    logic wr_dp_r;
    logic [3:0] gap_r;
    logic [7:0] hold_r;

    // Tick spacing is only judged between two ticks of one run period
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen_r <= 1'b0;
            wr_dp_r <= 1'b0;
            gap_r <= 4'h0;
            hold_r <= 8'h00;
        end
        else
        begin
            seen_r <= sys_rst_n && (seen_r || wdt_tick);
            wr_dp_r <= hsel && hready && htrans[1] && hwrite && haddr == `ADDR_CAUSE;
            gap_r <= wdt_tick ? 4'h0 : gap_r + {3'h0, gap_r != 4'hF};
            hold_r <= sys_rst_n ? 8'h00 : hold_r + {7'h00, hold_r != 8'hFF};
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_fetch;
        pc_load && pc_value == 16'h0000 && sysclk_internal_sel ##1 !pc_load;
    endsequence

    a_reset_halts: assert property (
        !sys_rst_n |-> cpu_halt && sfr_init && ram_write_block && irq_timer_disable)
        else $error("core not held in reset");
    a_ports_known: assert property (
        weak_pullup_en && (sys_rst_n || port_open_drain && port_latch_val == 8'hFF))
        else $error("port state wrong");
    a_pin_in_reset: assert property (rst_pin_oe |-> !sys_rst_n)
        else $error("pin driven outside reset");
    a_pin_cause: assert property (
        $rose(rst_pin_oe) |-> !$past(supply_above_threshold))
        else $error("pin driven without supply cause");
    a_exit_fetch: assert property ($rose(sys_rst_n) |-> s_fetch)
        else $error("no fetch restart at exit");
    a_wdt_rate: assert property (
        wdt_tick && sys_rst_n |-> wdt_enable && (!seen_r || gap_r == 4'hB))
        else $error("watchdog tick spacing wrong");
    a_wdt_gap: assert property (seen_r && sys_rst_n |-> gap_r <= 4'hB)
        else $error("watchdog tick missing");
    a_pin_resets: assert property (
        sys_rst_n && !rst_pin_i && !rst_pin_oe |-> ##[1:3] !sys_rst_n)
        else $error("pin low did not reset");
    a_soft_force: assert property (wr_dp_r && hwdata[4] |=> !sys_rst_n)
        else $error("software force ignored");
    a_hold_stretch: assert property (
        $rose(sys_rst_n) |-> hold_r >= STRETCH_CYC)
        else $error("reset released too early");
endmodule : rsc_checker

bind reset_source_controller rsc_checker #(.STRETCH_CYC(STRETCH_CYC),
    .CLK_LOSS_CYC(CLK_LOSS_CYC)) u_rsc_checker (.clk_sys, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .rst_pin_i, .rst_pin_oe, .supply_above_threshold,
    .sys_rst_n, .cpu_halt, .sfr_init, .ram_write_block, .irq_timer_disable,
    .port_latch_val, .port_open_drain, .weak_pullup_en, .pc_load, .pc_value,
    .sysclk_internal_sel, .wdt_enable, .wdt_tick);

// ### ext_reset_circuit.sv
// Board circuitry that can pull the open-drain reset pin low.
`timescale 1ns/100ps

module ext_reset_circuit (
    input logic clk_sys,
    input logic pull_req,
    input logic [3:0] extra_cyc,
    input logic rst_pin_o,
    input logic rst_pin_oe,
    output logic rst_pin_i
);
    logic [3:0] cnt_r = 4'h0;

    // A slow circuit keeps pulling for extra_cyc cycles after the request ends
    always @(posedge clk_sys)
        cnt_r <= pull_req ? extra_cyc : cnt_r - {3'h0, cnt_r != 4'h0};

    // Pull-up wins only when neither side pulls the wire
    assign rst_pin_i = !(pull_req || cnt_r != 4'h0) && !(rst_pin_oe && !rst_pin_o);
endmodule : ext_reset_circuit

// ### test_reset_source_controller.sv
// Self-checking bench for the reset source controller.
`timescale 1ns/100ps
`include "rsc_defs.svh"

module test_reset_source_controller;
    import rsc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic monitored_clk = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] src = 3'h0;
    logic hready, hreadyout, hresp, rst_pin_i, rst_pin_o, rst_pin_oe, sys_rst_n;
    logic supply_above_threshold, comparator_out_n, watchdog_overflow, flash_fault;
    logic cpu_halt, sfr_init, ram_write_block, port_latch_load, port_open_drain;
    logic weak_pullup_en, irq_timer_disable, pc_load, sysclk_internal_sel;
    logic wdt_enable, wdt_tick, low_seen, oe_seen;
    logic [31:0] hrdata;
    logic [7:0] port_latch_val;
    logic [15:0] pc_value;
    rst_state_t reset_phase;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    // Source codes: 1 pin, 2 watchdog, 3 flash, 4 comparator, 5 clock stop, 6 supply low
    assign hready = hreadyout;
    assign supply_above_threshold = src != 3'h6;
    assign comparator_out_n = src != 3'h4;
    assign watchdog_overflow = src == 3'h2;
    assign flash_fault = src == 3'h3;

    reset_source_controller #(.STRETCH_CYC(4), .CLK_LOSS_CYC(8)) u_reset_source_controller (
        .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .rst_pin_i, .rst_pin_o, .rst_pin_oe,
        .supply_above_threshold, .comparator_out_n, .watchdog_overflow, .flash_fault,
        .monitored_clk, .sys_rst_n, .cpu_halt, .sfr_init, .ram_write_block, .port_latch_val,
        .port_latch_load, .port_open_drain, .weak_pullup_en, .irq_timer_disable, .pc_load,
        .pc_value, .sysclk_internal_sel, .wdt_enable, .wdt_tick, .reset_phase);

    ext_reset_circuit u_ext_reset_circuit (.clk_sys, .pull_req(src == 3'h1),
        .extra_cyc(4'h3), .rst_pin_o, .rst_pin_oe, .rst_pin_i);

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (src != 3'h5)
            monitored_clk <= ~monitored_clk;
        if (cyc == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end

    always @(negedge clk_sys)
    begin
        low_seen |= !sys_rst_n;
        oe_seen |= rst_pin_oe;
        check("phase", reset_phase == ST_HOLD, !sys_rst_n);
        check("port load", port_latch_load, !sys_rst_n);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1)
            @(posedge clk_sys);
        q = hrdata;
        check("response", hresp, 32'h0);
    endtask : bus

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, e);
    endtask : rd

    task automatic trial(input logic [2:0] k, input logic [7:0] w, input logic [7:0] e,
        input logic [7:0] m);
        logic [31:0] q;
        low_seen = 1'b0;
        oe_seen = 1'b0;
        bus(1'b1, `ADDR_CAUSE, {24'h0, w}, q);
        src <= k;
        repeat (20) @(posedge clk_sys);
        src <= 3'h0;
        for (int n = 0; n < 60 && !(n > 8 && sys_rst_n === 1'b1); n++)
            @(posedge clk_sys);
        check("reset entered", low_seen, 1'b1);
        check("pin drive", oe_seen, k == 3'h6);
        bus(1'b0, `ADDR_CAUSE, 32'h0, q);
        check("cause", q & {24'h0, m}, {24'h0, e});
    endtask : trial

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    initial
    begin
        logic [31:0] q;
        repeat (16) @(posedge clk_sys);
        check("pin drive", rst_pin_oe, 1'b1);
        rst_n <= 1'b1;
        for (int n = 0; n < 40 && sys_rst_n !== 1'b1; n++)
            @(posedge clk_sys);
        rd("cause", `ADDR_CAUSE, 32'h02);
        rd("supply", `ADDR_SUPPLY, 32'hC0);
        rd("unmapped", 12'h010, 32'h0);
        bus(1'b1, `ADDR_CAUSE, 32'h0, q);
        // Disabled or deselected sources must leave the core running
        for (int k = 4; k < 7; k++)
        begin
            low_seen = 1'b0;
            src <= 3'(k);
            repeat (12) @(posedge clk_sys);
            rd("supply", `ADDR_SUPPLY, {24'h0, 1'b1, k != 6, 6'h0});
            check("no reset", low_seen, 1'b0);
            src <= 3'h0;
            @(posedge clk_sys);
        end
        bus(1'b1, `ADDR_SUPPLY, 32'h0, q);
        // Selected but switched off: the monitor must stay silent
        bus(1'b1, `ADDR_CAUSE, 32'h02, q);
        low_seen = 1'b0;
        src <= 3'h6;
        repeat (12) @(posedge clk_sys);
        check("monitor off", low_seen, 1'b0);
        src <= 3'h0;
        trial(3'h0, 8'h10, 8'h10, 8'hFF);
        rd("supply", `ADDR_SUPPLY, 32'h40);
        bus(1'b1, `ADDR_SUPPLY, 32'h80, q);
        repeat (20) @(posedge clk_sys);
        trial(3'h1, 8'h00, 8'h01, 8'hFF);
        trial(3'h2, 8'h00, 8'h08, 8'hFF);
        trial(3'h3, 8'h00, 8'h40, 8'hFF);
        trial(3'h4, 8'h20, 8'h20, 8'hFF);
        trial(3'h5, 8'h04, 8'h04, 8'hFF);
        trial(3'h6, 8'h02, 8'h02, 8'h02);
        finish_test();
    end
endmodule : test_reset_source_controller
